/* logic/wdg_pkg.sv */
package wdg_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PULSE_NS      = 500;
  localparam int unsigned PULSE_CYCLES  = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_PERIODS  = 16384;
  localparam int unsigned PULSE_W       = 4;
  localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYCLES - 1);

  // Register indices; byte address is four times the index
  localparam logic [11:0] CTRL_IDX    = 12'h02A;
  localparam logic [11:0] TMIN_IDX    = 12'h02B;
  localparam logic [11:0] TMAX_IDX    = 12'h02C;
  localparam logic [11:0] CTRL_ADDR   = 12'(CTRL_IDX * 4);
  localparam logic [11:0] TMIN_ADDR   = 12'(TMIN_IDX * 4);
  localparam logic [11:0] TMAX_ADDR   = 12'(TMAX_IDX * 4);

  // Control register layout and reset value
  localparam int unsigned CTRL_ACT_BIT = 7;
  localparam int unsigned CTRL_TOP_BIT = 6;
  localparam logic [7:0]  CTRL_RESET   = 8'h7F;
  localparam logic [6:0]  COUNT_RESET  = 7'h7F;
  localparam logic [6:0]  COUNT_EXPIRE = 7'h40;

  // Timeout estimate coefficients
  localparam int unsigned TMIN_BASE_ADD = 128;
  localparam int unsigned STEP_ADD      = 192;
  localparam int unsigned LSB_SCALE     = 64;
  localparam logic [6:0]  COEF_MSB [4]  = '{7'h04, 7'h08, 7'h14, 7'h31};
  localparam logic [6:0]  COEF_LSB [4]  = '{7'h3B, 7'h35, 7'h23, 7'h36};
  localparam int unsigned EST_W         = 24;

  typedef struct packed {
    logic hw_watchdog;
    logic stop_reset_option;
  } wdg_opt_t;

  typedef struct packed {
    logic [EST_W-1:0] tmin;
    logic [EST_W-1:0] tmax;
  } timeout_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_PULSE = 2'b10
  } pulse_state_t;

endpackage

/* logic/wdg_prescaler.sv */
`timescale 1ns/100ps
module wdg_prescaler
  import wdg_pkg::*;
#(
  parameter int unsigned DIV = TICK_PERIODS
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET_N,
  // Enable pulse
  output logic      TICK
);

  logic [$clog2(DIV)-1:0] phase_r;

  // Free phase, never touched by register writes
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      phase_r <= '0;
    end else if (phase_r == ($clog2(DIV))'(DIV - 1)) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      TICK <= 1'b0;
    end else begin
      TICK <= (phase_r == ($clog2(DIV))'(DIV - 1));
    end
  end

endmodule

/* logic/wdg_timeout_calc.sv */
`timescale 1ns/100ps
module wdg_timeout_calc
  import wdg_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  // Inputs
  input  wire logic [5:0] INCREMENT_COUNT,
  input  wire logic [1:0] TIMEBASE_SELECT,
  // Estimates in oscillator periods
  output timeout_t        EST
);

  logic [6:0]       msb;
  logic [6:0]       lsb;
  logic [6:0]       msb4;
  logic [6:0]       k;
  logic [EST_W-1:0] step_part;
  logic [EST_W-1:0] lin_part;
  logic [EST_W-1:0] tmin0;

  always_comb begin
    msb       = COEF_MSB[TIMEBASE_SELECT];                                  // see [R16]
    lsb       = COEF_LSB[TIMEBASE_SELECT];                                  // see [R16]
    msb4      = msb >> 2;
    k         = 7'((10'(INCREMENT_COUNT) * 10'h004) / 10'(msb));            // see [R17]
    lin_part  = EST_W'(TICK_PERIODS) * EST_W'(INCREMENT_COUNT);
    step_part = EST_W'(TICK_PERIODS) * EST_W'(7'(INCREMENT_COUNT) - k)
              + EST_W'(STEP_ADD + lsb) * EST_W'(LSB_SCALE) * EST_W'(k);
    tmin0     = EST_W'(lsb + TMIN_BASE_ADD) * EST_W'(LSB_SCALE);
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      EST <= '0;
    end else begin
      EST.tmin <= tmin0 + ((7'(INCREMENT_COUNT) < msb4) ? lin_part : step_part);                  // see [R14]
      EST.tmax <= EST_W'(TICK_PERIODS) + ((7'(INCREMENT_COUNT) <= msb4) ? lin_part : step_part);  // see [R15]
    end
  end

endmodule

/* logic/wdg_top.sv */
// Overview of operation
// [R1] Countdown drops by one every 16384 oscillator cycles.
// [R2] Low six countdown bits give 64 programmable timeout steps.
// [R3] When active, count passing 40h to 3Fh starts a system reset.
// [R4] Watchdog reset drives the reset pin low for 500 ns.
// [R5] Countdown keeps running when inactive; only reset depends on activation.
// [R6] Software rewrites control regularly with values FFh to C0h.
// [R7] Written low six bits set increments before reset.
// [R8] Writes never reset the prescaler phase, so timeout has bounds.
// [R9] After reset the watchdog is inactive unless hardware option chosen.
// [R10] Activation cannot be undone except by reset.
// [R11] Write with activate set and top bit clear forces reset.
// [R12] Active with stop option: stop instruction causes reset.
// [R13] Hardware option keeps watchdog always active.
// [R14] Minimum timeout follows the increment and timebase formula.
// [R15] Maximum timeout has a 16384 period base term.
// [R16] Timebase select picks the two coefficients.
// [R17] Increment count is the low six countdown bits.
// [R18] Activate bit is bit 7, set only by software.
// [R19] Control resets to 7Fh.
// [R20] Reads return activate bit and current countdown.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module wdg_top
  import wdg_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_PERIODS,
  parameter int unsigned AW       = 12
) (
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          RESET_N,
  // APB slave
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [AW-1:0] PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic [31:0]        PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  // Option straps and system inputs
  input  wire logic          HW_WATCHDOG,
  input  wire logic          STOP_RESET_OPTION,
  input  wire logic [1:0]    TIMEBASE_SELECT,
  input  wire logic          STOP_EXEC,
  // Status and reset pin
  output logic               WATCHDOG_ACTIVE,
  output logic               WDG_RESET_N
);

  logic         tick;
  timeout_t     est;
  wdg_opt_t     opt_r;
  logic         strap_taken_r;
  logic         activate_r;
  logic [6:0]   count_r;
  logic [6:0]   count_nxt;
  logic         pready_r;
  logic [31:0]  prdata_r;
  logic         pslverr_r;
  logic         pin_n_r;
  logic         active_r;
  pulse_state_t state_r;
  logic [PULSE_W-1:0] pcnt_r;

  logic         access;
  logic         wr_ctrl;
  logic         hit_ctrl;
  logic         hit_tmin;
  logic         hit_tmax;
  logic         hit_any;
  logic         active;
  logic         sw_reset_req;
  logic         expire_req;
  logic         stop_req;
  logic         trigger;
  logic [6:0]   wdata_low;

  // Check clocking for the whole module
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  wdg_prescaler #(
    .DIV     (TICK_DIV)
  ) u_prescaler (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .TICK    (tick)
  );

  wdg_timeout_calc u_calc (
    .CLK             (CLK),
    .RESET_N         (RESET_N),
    .INCREMENT_COUNT (count_r[5:0]),
    .TIMEBASE_SELECT (TIMEBASE_SELECT),
    .EST             (est)
  );

  // Bus decode
  always_comb begin
    hit_ctrl  = (PADDR == AW'(CTRL_ADDR));
    hit_tmin  = (PADDR == AW'(TMIN_ADDR));
    hit_tmax  = (PADDR == AW'(TMAX_ADDR));
    hit_any   = hit_ctrl | hit_tmin | hit_tmax;
    access    = PSEL & PENABLE & pready_r;
    wr_ctrl   = access & PWRITE & hit_ctrl;
    wdata_low = PWDATA[6:0];
  end

  // Trigger sources
  always_comb begin
    active       = activate_r | (opt_r.hw_watchdog & strap_taken_r);                        // see [R13]
    sw_reset_req = wr_ctrl & PWDATA[CTRL_ACT_BIT] & ~PWDATA[CTRL_TOP_BIT];                 // see [R11]
    expire_req   = active & tick & (count_r == COUNT_EXPIRE) & ~wr_ctrl;                    // see [R3]
    stop_req     = active & opt_r.stop_reset_option & strap_taken_r & STOP_EXEC;            // see [R12]
    trigger      = sw_reset_req | expire_req | stop_req;
  end

  // Straps caught after reset release
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      opt_r         <= '0;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      opt_r.hw_watchdog       <= HW_WATCHDOG;                                               // see [R9]
      opt_r.stop_reset_option <= STOP_RESET_OPTION;
      strap_taken_r           <= 1'b1;
    end
  end

  a_strap_hold: assert property (strap_taken_r |=> $stable(opt_r)) // see [R13]
    else $error("option straps changed after capture");

  // Activate bit: set only
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      activate_r <= CTRL_RESET[CTRL_ACT_BIT];                                               // see [R9]
    end else if (wr_ctrl && PWDATA[CTRL_ACT_BIT]) begin
      activate_r <= 1'b1;                                                                   // see [R18] [R10]
    end
  end

  a_act_set: assert property (wr_ctrl && PWDATA[CTRL_ACT_BIT] |=> activate_r) // see [R18]
    else $error("activate bit not set by write");
  a_act_only_write: assert property (!activate_r && !wr_ctrl |=> !activate_r) // see [R9]
    else $error("activate bit set without write");

  // Countdown
  always_comb begin
    count_nxt = count_r;
    if (wr_ctrl) begin
      count_nxt = wdata_low;                                                                // see [R2] [R7]
    end else if (tick) begin
      count_nxt = count_r - 7'h01;                                                          // see [R1] [R5] [R8]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      count_r <= COUNT_RESET;                                                               // see [R19]
    end else begin
      count_r <= count_nxt;
    end
  end

  a_count_hold: assert property (!tick && !wr_ctrl |=> $stable(count_r)) // see [R1]
    else $error("countdown moved without tick");

  // Reset pulse generator
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_r <= ST_IDLE;
      pcnt_r  <= '0;
      pin_n_r <= 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (trigger) begin
            state_r <= ST_PULSE;
            pcnt_r  <= PULSE_LOAD;                                                          // see [R4]
            pin_n_r <= 1'b0;
          end
        end
        ST_PULSE: begin
          if (pcnt_r == '0) begin
            state_r <= ST_IDLE;
            pin_n_r <= 1'b1;
          end else begin
            pcnt_r  <= pcnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  a_pulse_busy: assert property (state_r == ST_PULSE |-> !pin_n_r) // see [R4]
    else $error("reset pin high during pulse");
  a_pulse_idle: assert property (state_r == ST_IDLE |-> pin_n_r) // see [R4]
    else $error("reset pin low while idle");

  // APB answer, one wait state
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= PSEL & PENABLE & ~pready_r;
      if (PSEL && PENABLE && !pready_r) begin
        pslverr_r <= ~hit_any;
        prdata_r  <= '0;
        if (!PWRITE && hit_ctrl) begin
          prdata_r <= {24'h000000, active, count_r};                                        // see [R20]
        end else if (!PWRITE && hit_tmin) begin
          prdata_r <= 32'(est.tmin);
        end else if (!PWRITE && hit_tmax) begin
          prdata_r <= 32'(est.tmax);
        end
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  a_ready_wait: assert property (PSEL && PENABLE && !pready_r |=> PREADY) // see [R20]
    else $error("ready not given after one wait state");
  a_ready_single: assert property (pready_r |=> !PREADY) // see [R20]
    else $error("ready held too long");
  a_err_unmapped: assert property (PSEL && PENABLE && !pready_r && !hit_any |=> PSLVERR) // see [R20]
    else $error("unmapped access without error");

  a_act_out: assert property (1'b1 |=> WATCHDOG_ACTIVE == $past(active)) // see [R13]
    else $error("active status not following activation");

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      active_r <= 1'b0;
    end else begin
      active_r <= active;
    end
  end

  always_comb begin
    PRDATA          = prdata_r;
    PREADY          = pready_r;
    PSLVERR         = pslverr_r;
    WDG_RESET_N     = pin_n_r;
    WATCHDOG_ACTIVE = active_r;
  end

  // Checks
  a_pulse_low: assert property ($fell(pin_n_r) |-> (!pin_n_r)[*8]) // see [R4]
    else $error("reset pulse too short");
  a_pulse_end: assert property ($fell(pin_n_r) |-> ##10 pin_n_r) // see [R4]
    else $error("reset pulse not ten cycles");
  a_expire_fires: assert property (expire_req && state_r == ST_IDLE |=> !pin_n_r) // see [R3]
    else $error("expiry did not start reset");
  a_count_step: assert property (tick && !wr_ctrl |=> count_r == 7'($past(count_r) - 7'h01)) // see [R1]
    else $error("countdown did not step");
  a_inactive_quiet: assert property (state_r == ST_IDLE && !trigger |=> pin_n_r) // see [R5]
    else $error("reset without cause");
  a_active_sticky: assert property (activate_r |=> activate_r) // see [R10]
    else $error("activation was undone");
  a_sw_reset: assert property (sw_reset_req && state_r == ST_IDLE |=> !pin_n_r) // see [R11]
    else $error("software reset missing");
  a_stop_reset: assert property (stop_req && state_r == ST_IDLE |=> !pin_n_r) // see [R12]
    else $error("stop reset missing");
  a_count_load: assert property (wr_ctrl |=> count_r == $past(wdata_low)) // see [R7]
    else $error("countdown not loaded");
  a_hw_active: assert property (opt_r.hw_watchdog && strap_taken_r |=> WATCHDOG_ACTIVE) // see [R13]
    else $error("hardware watchdog not active");
  a_reset_value: assert property ($rose(RESET_N) |-> count_r == COUNT_RESET && !activate_r) // see [R19]
    else $error("bad reset value");
  a_read_ctrl: assert property (PSEL && PENABLE && !pready_r && !PWRITE && hit_ctrl
                                |=> PRDATA[7:0] == {$past(active), $past(count_r)}) // see [R20]
    else $error("control readback wrong");

  c_expire: cover property (expire_req ##1 !pin_n_r);
  c_sw_reset: cover property (sw_reset_req ##1 !pin_n_r);
  c_stop_reset: cover property (stop_req ##1 !pin_n_r);
  c_refresh: cover property (wr_ctrl && PWDATA[7:6] == 2'b11);
  c_hw_expire: cover property (opt_r.hw_watchdog && expire_req);

endmodule

/* tb/windowed_countdown_watchdog_tb.sv */
`timescale 1ns/100ps
module windowed_countdown_watchdog_tb;
  import wdg_pkg::*;
  localparam int TD = 64;
  logic        CLK;
  logic        RESET_N;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        HW_WATCHDOG;
  logic        STOP_RESET_OPTION;
  logic [1:0]  TIMEBASE_SELECT;
  logic        STOP_EXEC;
  logic        WATCHDOG_ACTIVE;
  logic        WDG_RESET_N;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          comparisons;
  int          msb [4] = '{4, 8, 20, 49};
  int          lsb [4] = '{59, 53, 35, 54};

  wdg_top #(.TICK_DIV(TD)) DUT (
    .CLK(CLK), .RESET_N(RESET_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .HW_WATCHDOG(HW_WATCHDOG), .STOP_RESET_OPTION(STOP_RESET_OPTION),
    .TIMEBASE_SELECT(TIMEBASE_SELECT), .STOP_EXEC(STOP_EXEC),
    .WATCHDOG_ACTIVE(WATCHDOG_ACTIVE), .WDG_RESET_N(WDG_RESET_N)
  );

  initial CLK = 1'b0;
  always #25 CLK = ~CLK;

  task final_report();
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer, held until PREADY is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        final_report();
      end
      @(posedge CLK);
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Waits up to lim cycles for a reset pulse and measures its width
  task pulse(input int lim, input logic exp, output int n);
    int w;
    n = 0;
    w = 0;
    while (WDG_RESET_N === 1'b1 && n < lim) begin
      @(posedge CLK);
      n++;
    end
    while (WDG_RESET_N === 1'b0 && w < 40) begin
      @(posedge CLK);
      w++;
    end
    check("pulse_seen", {31'h0, w > 0}, {31'h0, exp});
    if (exp) check("pulse_len", 32'(w), 32'(PULSE_CYCLES));
  endtask

  task do_reset(input logic hw, input logic so);
    @(posedge CLK);
    RESET_N <= 1'b0;
    HW_WATCHDOG <= hw;
    STOP_RESET_OPTION <= so;
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (2) @(posedge CLK);
  endtask

  task stop_pulse();
    @(posedge CLK);
    STOP_EXEC <= 1'b1;
    @(posedge CLK);
    STOP_EXEC <= 1'b0;
  endtask

  // Timeout estimate in oscillator periods
  function automatic logic [31:0] est(input int c, input int ts, input logic mx);
    int m4;
    int k;
    int r;
    m4 = msb[ts] / 4;
    k = 4 * c / msb[ts];
    r = mx ? 16384 : (lsb[ts] + 128) * 64;
    if (mx ? c <= m4 : c < m4) r += 16384 * c;
    else r += 16384 * (c - k) + (192 + lsb[ts]) * 64 * k;
    return 32'(r);
  endfunction

  initial begin
    int n;
    int c;
    RESET_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    HW_WATCHDOG = 1'b0;
    STOP_RESET_OPTION = 1'b1;
    TIMEBASE_SELECT = 2'h0;
    STOP_EXEC = 1'b0;
    errors = 0;
    comparisons = 0;
    do_reset(1'b0, 1'b1);
    check("active", {31'h0, WATCHDOG_ACTIVE}, 32'h0);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("ctrl_reset", rd, 32'h7F);
    apb(1'b1, 12'h000, 32'hFF);
    check("slverr", {31'h0, er}, 32'h1);
    check("active", {31'h0, WATCHDOG_ACTIVE}, 32'h0);
    stop_pulse();
    pulse(20, 1'b0, n);
    apb(1'b1, CTRL_ADDR, 32'h45);
    pulse(10 * TD, 1'b0, n);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("free_run", {31'h0, rd === 32'h3B || rd === 32'h3A}, 32'h1);
    $display("Test reset_free_run done");
    apb(1'b1, CTRL_ADDR, 32'hC2);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("act_rd", {31'h0, rd === 32'hC2 || rd === 32'hC1}, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h7F);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("no_deact", {31'h0, rd === 32'hFF || rd === 32'hFE}, 32'h1);
    check("active", {31'h0, WATCHDOG_ACTIVE}, 32'h1);
    stop_pulse();
    pulse(20, 1'b1, n);
    apb(1'b1, CTRL_ADDR, 32'hC3);
    pulse(5 * TD, 1'b1, n);
    check("expiry_time", {31'h0, n >= 3 * TD && n <= 4 * TD + 3}, 32'h1);
    do_reset(1'b0, 1'b0);
    check("active", {31'h0, WATCHDOG_ACTIVE}, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'hBF);
    pulse(20, 1'b1, n);
    $display("Test activation_expiry done");
    do_reset(1'b0, 1'b0);
    for (int ts = 0; ts < 4; ts++) begin
      for (int i = 0; i < 3; i++) begin
        c = (i == 0) ? 1 : (i == 1) ? 5 : 63;
        TIMEBASE_SELECT <= 2'(ts);
        apb(1'b1, CTRL_ADDR, 32'h40 | 32'(c));
        apb(1'b0, TMIN_ADDR, 32'h0);
        check("tmin", {31'h0, rd === est(c, ts, 0) || rd === est(c - 1, ts, 0)}, 32'h1);
        apb(1'b0, TMAX_ADDR, 32'h0);
        check("tmax", {31'h0, rd === est(c, ts, 1) || rd === est(c - 1, ts, 1)}, 32'h1);
      end
    end
    $display("Test estimates done");
    do_reset(1'b1, 1'b0);
    @(posedge CLK);
    check("hw_active", {31'h0, WATCHDOG_ACTIVE}, 32'h1);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("hw_act_bit", {31'h0, rd[7]}, 32'h1);
    $display("Test hw_option done");
    final_report();
  end
endmodule
